// ---- rtl/nds_dev.sv ----
// non-restoring divide step unit: accumulators, data registers, flags
//
// Operation
// RL1 - one quotient bit per non-restoring step
// RL2 - xor accumulator bit 35 with divisor bit 15
// RL3 - shift accumulator left, carry into bit 0
// RL4 - add or subtract divisor on upper portion
// RL5 - sign-extended divisor; carry gives quotient bit
// RL6 - carry set when result bit 35 clear
// RL7 - overflow set when shift changes sign bit
// RL8 - limit set with overflow, never cleared; code clears it on lim_clr
// RL9 - quotient grows in low word from bit 0
// RL10 - step takes two cycles, one word
// RL11 - issuer runs step n times, 1 to 16
// RL12 - issuer loads positive sign-extended 32-bit dividend
// RL13 - fractional: dividend magnitude below divisor magnitude
// RL14 - issuer undoes final step for true remainder
// RL15 - issuer negates quotient when result negative
// RL16 - divisor from data registers, either accumulator
`timescale 1ns/1ps
module nds_dev
    import nds_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    nds_if.dev        lnk,
    input  wire logic lim_clr,
    output logic      busy
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        nds_dev_st_e                       st;
        logic [NDS_CNT_W-1:0]              cnt;
        logic [NDS_SEL_W-1:0]              src;
        logic                              dst;
        logic                              add;
        logic [NDS_ACC_W-1:0]              acc_a;
        logic [NDS_ACC_W-1:0]              acc_b;
        logic [NDS_NREG-1:0][NDS_DIV_W-1:0] dreg;
        logic                              c;
        logic                              v;
        logic                              l;
        logic                              ready;
        logic                              done;
        logic                              busy;
    } nds_dev_s;

    nds_dev_s s_r;
    nds_dev_s s_nxt;

    // ********************************************************
    // one divide iteration: returns {c, v, acc}
    // ********************************************************
    function automatic logic [NDS_ACC_W+1:0] nds_iter(input logic [NDS_ACC_W-1:0] acc,
                                                     input logic [NDS_DIV_W-1:0] dvs,
                                                     input logic                 cin,
                                                     input logic                 add);
        logic [NDS_ACC_W-1:0] sh;
        logic [NDS_UP_W-1:0]  up;
        logic [NDS_UP_W-1:0]  sum;
        logic                 ovf;
        sh  = {acc[NDS_ACC_W-2:0], cin};                                // [RL3] [RL9]
        ovf = acc[NDS_ACC_SIGN] ^ acc[NDS_ACC_SIGN-1];                  // [RL7]
        up  = sh[NDS_ACC_W-1:NDS_LOW_W];
        // full-width extension keeps carry right
        if (add) begin
            sum = up + nds_sext(dvs);                                   // [RL4] [RL5]
        end else begin
            sum = up - nds_sext(dvs);                                   // [RL4] [RL5]
        end
        return {~sum[NDS_UP_W-1], ovf, sum, sh[NDS_LOW_W-1:0]};         // [RL6] [RL1]
    endfunction

    // operand pick, decode and execute
    function automatic logic [NDS_ACC_W-1:0] nds_pick_acc(input nds_dev_s s, input logic sel);
        return sel ? s.acc_b : s.acc_a;                                 // [RL16]
    endfunction

    logic [NDS_ACC_W+1:0] iter_res;
    logic [NDS_ACC_W-1:0] cur_acc;

    always_comb begin
        cur_acc  = nds_pick_acc(s_r, s_r.dst);
        iter_res = nds_iter(cur_acc, s_r.dreg[s_r.src], s_r.c, s_r.add);
    end

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            NDS_IDLE: begin
                if (lnk.step_valid) begin
                    // same-cycle loads dropped so sign
                    // compare and shift see one operand set
                    s_nxt.src   = lnk.step_src_sel;                     // [RL16]
                    s_nxt.dst   = lnk.step_dst_sel;                     // [RL16]
                    s_nxt.add   = nds_pick_acc(s_r, lnk.step_dst_sel)[NDS_ACC_SIGN]
                                  ^ s_r.dreg[lnk.step_src_sel][NDS_DIV_SIGN];   // [RL2]
                    s_nxt.st    = NDS_EXEC;
                    s_nxt.cnt   = NDS_CNT_W'(1);
                    s_nxt.ready = 1'b0;
                    s_nxt.busy  = 1'b1;
                end else begin
                    if (lnk.acc_wr_en) begin
                        if (lnk.acc_wr_sel) begin
                            s_nxt.acc_b = lnk.acc_wr_data;
                        end else begin
                            s_nxt.acc_a = lnk.acc_wr_data;
                        end
                    end
                    if (lnk.reg_wr_en) begin
                        s_nxt.dreg[lnk.reg_wr_sel] = lnk.reg_wr_data;
                    end
                    if (lnk.c_wr_en) begin
                        s_nxt.c = lnk.c_wr_val;
                    end
                end
            end
            NDS_EXEC: begin
                if (s_r.cnt == NDS_CNT_W'(NDS_STEP_CLKS - 1)) begin     // [RL10]
                    if (s_r.dst) begin
                        s_nxt.acc_b = iter_res[NDS_ACC_W-1:0];          // [RL1] [RL9]
                    end else begin
                        s_nxt.acc_a = iter_res[NDS_ACC_W-1:0];          // [RL1] [RL9]
                    end
                    s_nxt.c     = iter_res[NDS_ACC_W+1];                // [RL6]
                    s_nxt.v     = iter_res[NDS_ACC_W];                  // [RL7]
                    s_nxt.st    = NDS_IDLE;
                    s_nxt.ready = 1'b1;
                    s_nxt.busy  = 1'b0;
                    s_nxt.done  = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + NDS_CNT_W'(1);
                end
            end
            default: begin
                s_nxt.st    = NDS_IDLE;
                s_nxt.ready = 1'b1;
                s_nxt.busy  = 1'b0;
            end
        endcase
        // sticky limit: overflow beats clear
        if (lim_clr) begin
            s_nxt.l = 1'b0;
        end
        if (s_r.st == NDS_EXEC && s_r.cnt == NDS_CNT_W'(NDS_STEP_CLKS - 1) && iter_res[NDS_ACC_W]) begin
            s_nxt.l = 1'b1;                                             // [RL8]
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r.st    <= NDS_IDLE;
            s_r.cnt   <= '0;
            s_r.src   <= '0;
            s_r.dst   <= 1'b0;
            s_r.add   <= 1'b0;
            s_r.acc_a <= NDS_ACC_RST;
            s_r.acc_b <= NDS_ACC_RST;
            s_r.dreg  <= {NDS_NREG{NDS_REG_RST}};
            s_r.c     <= 1'b0;
            s_r.v     <= 1'b0;
            s_r.l     <= 1'b0;
            s_r.ready <= 1'b1;
            s_r.done  <= 1'b0;
            s_r.busy  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign lnk.step_ready = s_r.ready;
    assign lnk.step_done  = s_r.done;
    assign lnk.acc_a      = s_r.acc_a;
    assign lnk.acc_b      = s_r.acc_b;
    assign lnk.flag_c     = s_r.c;
    assign lnk.flag_v     = s_r.v;
    assign lnk.flag_l     = s_r.l;
    assign busy           = s_r.busy;

endmodule

// ---- rtl/nds_pkg.sv ----
// constants, types and helpers for the divide step
package nds_pkg;

    // ********************************************************
    // data path geometry
    // ********************************************************
    localparam int NDS_ACC_W      = 36;
    localparam int NDS_DIV_W      = 16;
    localparam int NDS_LOW_W      = 16;
    localparam int NDS_UP_W       = NDS_ACC_W - NDS_LOW_W;
    localparam int NDS_ACC_SIGN   = 35;
    localparam int NDS_DIV_SIGN   = 15;
    localparam int NDS_DVD_W      = 32;
    localparam int NDS_DVD_SIGN   = 31;
    localparam int NDS_NREG       = 4;
    localparam int NDS_SEL_W      = 2;
    localparam int NDS_QBITS_MAX  = 16;
    localparam int NDS_NB_W       = 5;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int NDS_CLK_PS     = 5000;
    localparam int NDS_OSC_PS     = 5000;
    localparam int NDS_STEP_OSC   = 2;
    localparam int NDS_STEP_CLKS  = (NDS_STEP_OSC * NDS_OSC_PS + NDS_CLK_PS - 1) / NDS_CLK_PS;
    localparam int NDS_CNT_W      = 2;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [NDS_ACC_W-1:0] NDS_ACC_RST = 36'h0;
    localparam logic [NDS_DIV_W-1:0] NDS_REG_RST = 16'h0;

    // ********************************************************
    // state types
    // ********************************************************
    typedef enum logic {NDS_IDLE, NDS_EXEC} nds_dev_st_e;
    typedef enum logic [2:0] {NDS_H_IDLE, NDS_H_LDREG, NDS_H_LDACC, NDS_H_ISSUE,
                              NDS_H_WAIT, NDS_H_FIX} nds_host_st_e;

    // divisor sign-extended to upper width
    function automatic logic [NDS_UP_W-1:0] nds_sext(input logic [NDS_DIV_W-1:0] d);
        return {{(NDS_UP_W - NDS_DIV_W){d[NDS_DIV_SIGN]}}, d};
    endfunction

endpackage

// ---- rtl/nds_if.sv ----
// link between the divide step unit and the instruction issuer
`timescale 1ns/1ps
interface nds_if;
    import nds_pkg::*;

    logic                 step_valid;
    logic                 step_ready;
    logic                 step_done;
    logic [NDS_SEL_W-1:0] step_src_sel;
    logic                 step_dst_sel;
    logic                 acc_wr_en;
    logic                 acc_wr_sel;
    logic [NDS_ACC_W-1:0] acc_wr_data;
    logic                 reg_wr_en;
    logic [NDS_SEL_W-1:0] reg_wr_sel;
    logic [NDS_DIV_W-1:0] reg_wr_data;
    logic                 c_wr_en;
    logic                 c_wr_val;
    logic [NDS_ACC_W-1:0] acc_a;
    logic [NDS_ACC_W-1:0] acc_b;
    logic                 flag_c;
    logic                 flag_v;
    logic                 flag_l;

    modport dev (
        input  step_valid,
        output step_ready,
        output step_done,
        input  step_src_sel,
        input  step_dst_sel,
        input  acc_wr_en,
        input  acc_wr_sel,
        input  acc_wr_data,
        input  reg_wr_en,
        input  reg_wr_sel,
        input  reg_wr_data,
        input  c_wr_en,
        input  c_wr_val,
        output acc_a,
        output acc_b,
        output flag_c,
        output flag_v,
        output flag_l
    );

    modport host (
        output step_valid,
        input  step_ready,
        input  step_done,
        output step_src_sel,
        output step_dst_sel,
        output acc_wr_en,
        output acc_wr_sel,
        output acc_wr_data,
        output reg_wr_en,
        output reg_wr_sel,
        output reg_wr_data,
        output c_wr_en,
        output c_wr_val,
        input  acc_a,
        input  acc_b,
        input  flag_c,
        input  flag_v,
        input  flag_l
    );
endinterface

// ---- rtl/nds_host.sv ----
// issuer: loads operands, runs steps, fixes result
`timescale 1ns/1ps
module nds_host
    import nds_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    nds_if.host                       lnk,
    input  wire logic                 start,
    input  wire logic [NDS_DVD_W-1:0] dividend,
    input  wire logic [NDS_DIV_W-1:0] divisor,
    input  wire logic [NDS_NB_W-1:0]  nbits,
    input  wire logic [NDS_SEL_W-1:0] src_sel,
    input  wire logic                 dst_sel,
    output logic [NDS_DIV_W-1:0]      quotient,
    output logic [NDS_UP_W-1:0]       remainder,
    output logic                      done,
    output logic                      busy,
    output logic                      invalid
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        nds_host_st_e          st;
        logic [NDS_NB_W-1:0]   nb;
        logic [NDS_NB_W-1:0]   cnt;
        logic                  qneg;
        logic                  rneg;
        logic [NDS_DVD_W-1:0]  dmag;
        logic [NDS_DIV_W-1:0]  smag;
        logic [NDS_SEL_W-1:0]  src;
        logic                  dst;
        logic                  step_valid;
        logic                  acc_wr_en;
        logic                  reg_wr_en;
        logic                  c_wr_en;
        logic [NDS_DIV_W-1:0]  q;
        logic [NDS_UP_W-1:0]   r;
        logic                  done;
        logic                  busy;
        logic                  inval;
    } nds_host_s;

    nds_host_s s_r;
    nds_host_s s_nxt;

    logic [NDS_ACC_W-1:0] fin;
    logic [NDS_UP_W-1:0]  up_fix;
    logic [NDS_DIV_W-1:0] qmask;
    logic [NDS_DIV_W-1:0] qmag;
    logic [NDS_DIV_W-1:0] smag_in;

    always_comb begin
        fin     = s_r.dst ? lnk.acc_b : lnk.acc_a;
        smag_in = divisor[NDS_DIV_SIGN] ? NDS_DIV_W'(-divisor) : divisor;
        // magnitudes fed: negative remainder means
        // last subtract went once too far
        up_fix  = fin[NDS_ACC_W-1:NDS_LOW_W];
        if (fin[NDS_ACC_SIGN]) begin
            up_fix = up_fix + nds_sext(s_r.smag);                       // [RL14]
        end
        qmask   = {NDS_DIV_W{1'b1}} >> (NDS_QBITS_MAX - int'(s_r.nb));
        qmag    = {fin[NDS_LOW_W-2:0], lnk.flag_c} & qmask;             // [RL9]
    end

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            NDS_H_IDLE: begin
                if (start) begin
                    s_nxt.qneg  = dividend[NDS_DVD_SIGN] ^ divisor[NDS_DIV_SIGN];
                    s_nxt.rneg  = dividend[NDS_DVD_SIGN];
                    s_nxt.dmag  = dividend[NDS_DVD_SIGN] ? NDS_DVD_W'(-dividend) : dividend;
                    s_nxt.smag  = smag_in;
                    // step count outside 1..16 runs full precision
                    s_nxt.nb    = (nbits == '0 || nbits > NDS_NB_W'(NDS_QBITS_MAX))
                                  ? NDS_NB_W'(NDS_QBITS_MAX) : nbits;   // [RL11]
                    s_nxt.inval = (smag_in == '0) ||
                                  ((dividend[NDS_DVD_SIGN] ? NDS_DVD_W'(-dividend) : dividend)
                                   >= {smag_in, {NDS_LOW_W{1'b0}}});    // [RL13]
                    s_nxt.src       = src_sel;
                    s_nxt.dst       = dst_sel;
                    s_nxt.cnt       = '0;
                    s_nxt.busy      = 1'b1;
                    s_nxt.reg_wr_en = 1'b1;
                    s_nxt.st        = NDS_H_LDREG;
                end
            end
            NDS_H_LDREG: begin
                s_nxt.reg_wr_en = 1'b0;
                s_nxt.acc_wr_en = 1'b1;                                 // [RL12]
                s_nxt.c_wr_en   = 1'b1;
                s_nxt.st        = NDS_H_LDACC;
            end
            NDS_H_LDACC: begin
                s_nxt.acc_wr_en = 1'b0;
                s_nxt.c_wr_en   = 1'b0;
                s_nxt.st        = NDS_H_ISSUE;
            end
            NDS_H_ISSUE: begin
                if (lnk.step_ready) begin
                    s_nxt.step_valid = 1'b1;
                    s_nxt.st         = NDS_H_WAIT;
                end
            end
            NDS_H_WAIT: begin
                s_nxt.step_valid = 1'b0;
                if (lnk.step_done) begin
                    s_nxt.cnt = s_r.cnt + NDS_NB_W'(1);
                    if (s_r.cnt + NDS_NB_W'(1) == s_r.nb) begin         // [RL11]
                        s_nxt.st = NDS_H_FIX;
                    end else begin
                        s_nxt.st = NDS_H_ISSUE;
                    end
                end
            end
            NDS_H_FIX: begin
                s_nxt.q    = s_r.qneg ? NDS_DIV_W'(-qmag) : qmag;       // [RL15]
                s_nxt.r    = s_r.rneg ? NDS_UP_W'(-up_fix) : up_fix;    // [RL14]
                s_nxt.done = 1'b1;
                s_nxt.busy = 1'b0;
                s_nxt.st   = NDS_H_IDLE;
            end
            default: begin
                s_nxt.st = NDS_H_IDLE;
            end
        endcase
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign lnk.step_valid   = s_r.step_valid;
    assign lnk.step_src_sel = s_r.src;
    assign lnk.step_dst_sel = s_r.dst;
    assign lnk.acc_wr_en    = s_r.acc_wr_en;
    assign lnk.acc_wr_sel   = s_r.dst;
    assign lnk.acc_wr_data  = {{(NDS_ACC_W - NDS_DVD_W){1'b0}}, s_r.dmag};   // [RL12]
    assign lnk.reg_wr_en    = s_r.reg_wr_en;
    assign lnk.reg_wr_sel   = s_r.src;
    assign lnk.reg_wr_data  = s_r.smag;
    assign lnk.c_wr_en      = s_r.c_wr_en;
    assign lnk.c_wr_val     = 1'b0;
    assign quotient         = s_r.q;
    assign remainder        = s_r.r;
    assign done             = s_r.done;
    assign busy             = s_r.busy;
    assign invalid          = s_r.inval;

endmodule

// ---- verif/nds_asserts.sv ----
// concurrent checks on the divide step link
`timescale 1ns/1ps
module nds_asserts
    import nds_pkg::*;
(
    input wire logic                 clk_sys,
    input wire logic                 reset,
    input wire logic                 step_valid,
    input wire logic                 step_ready,
    input wire logic                 step_done,
    input wire logic [NDS_SEL_W-1:0] step_src_sel,
    input wire logic                 step_dst_sel,
    input wire logic                 acc_wr_en,
    input wire logic                 acc_wr_sel,
    input wire logic [NDS_ACC_W-1:0] acc_wr_data,
    input wire logic                 reg_wr_en,
    input wire logic [NDS_SEL_W-1:0] reg_wr_sel,
    input wire logic [NDS_DIV_W-1:0] reg_wr_data,
    input wire logic [NDS_ACC_W-1:0] acc_a,
    input wire logic [NDS_ACC_W-1:0] acc_b,
    input wire logic                 flag_c,
    input wire logic                 flag_v,
    input wire logic                 flag_l
);
    // ********************************************************
    // shadow regs and expected result
    // ********************************************************
    logic [NDS_DIV_W-1:0] regs_r [NDS_NREG];
    logic [NDS_ACC_W-1:0] exp_r;
    logic                 exp_v_r;
    logic                 dsel_r;
    logic [NDS_ACC_W-1:0] acc_in;
    logic [NDS_ACC_W-1:0] acc_out;
    logic [NDS_ACC_W-1:0] sh;
    logic [NDS_DIV_W-1:0] dvs;
    logic [NDS_UP_W-1:0]  dvs_x;
    logic                 idle_ld;
    assign idle_ld = step_ready && !step_valid;
    assign acc_in  = step_dst_sel ? acc_b : acc_a;
    assign acc_out = dsel_r ? acc_b : acc_a;
    assign sh      = {acc_in[NDS_ACC_W-2:0], flag_c};
    assign dvs     = regs_r[step_src_sel];
    // own sign extension, independent of design
    assign dvs_x   = {{4{dvs[15]}}, dvs};
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regs_r  <= '{default: 16'h0};
            exp_r   <= 36'h0;
            exp_v_r <= 1'b0;
            dsel_r  <= 1'b0;
        end else begin
            if (reg_wr_en && idle_ld) begin
                regs_r[reg_wr_sel] <= reg_wr_data;
            end
            if (step_valid && step_ready) begin
                dsel_r        <= step_dst_sel;
                exp_v_r       <= acc_in[35] ^ acc_in[34];
                exp_r[15:0]   <= sh[15:0];
                exp_r[35:16]  <= (acc_in[35] ^ dvs[15]) ? sh[35:16] + dvs_x : sh[35:16] - dvs_x;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_take;
        step_valid && step_ready;
    endsequence
    sequence s_exec;
        !step_ready && !step_done ##1 step_ready && step_done;
    endsequence

    property p_step_lat;
        s_take |=> s_exec;
    endproperty
    a_step_lat: assert property (p_step_lat) else $error("step latency");
    property p_done_cause;
        step_done |-> $past(step_valid && step_ready, 2);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without step");
    property p_upper;
        step_done |-> acc_out[35:16] == exp_r[35:16];
    endproperty
    a_upper: assert property (p_upper) else $error("upper portion");
    property p_low;
        s_take ##2 step_done |-> acc_out[15:0] == exp_r[15:0];
    endproperty
    a_low: assert property (p_low) else $error("low word");
    property p_carry;
        step_done |-> flag_c == !acc_out[35];
    endproperty
    a_carry: assert property (p_carry) else $error("carry");
    property p_ovf;
        step_done |-> flag_v == exp_v_r;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow");
    property p_limit;
        step_done && flag_v |-> flag_l;
    endproperty
    a_limit: assert property (p_limit) else $error("limit");
    property p_lim_cause;
        $rose(flag_l) |-> step_done && flag_v;
    endproperty
    a_lim_cause: assert property (p_lim_cause) else $error("limit cause");
    property p_other_acc;
        step_done |-> (dsel_r ? acc_a == $past(acc_a, 2) : acc_b == $past(acc_b, 2));
    endproperty
    a_other_acc: assert property (p_other_acc) else $error("other accumulator");
    property p_load;
        acc_wr_en && idle_ld |=> ($past(acc_wr_sel) ? acc_b : acc_a) == $past(acc_wr_data);
    endproperty
    a_load: assert property (p_load) else $error("load");
endmodule

// ---- verif/test_nds.sv ----
// bench: issuer with step unit, plus a bare step unit
`timescale 1ns/1ps
module test_nds
    import nds_pkg::*;
;
    logic        clk_sys;
    logic        reset;
    logic        start;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic [4:0]  nbits;
    logic [1:0]  src_sel;
    logic        dst_sel;
    logic [15:0] quotient;
    logic [19:0] remainder;
    logic        done;
    logic        invalid;
    logic        lim_clr2;
    logic        busy2;
    int          bad_count = 0;
    int          checks_done = 0;

    nds_if lnk ();
    nds_if lnk2 ();
    // limit clear tested on the bare unit only
    nds_dev u_nds_dev (.clk_sys(clk_sys), .reset(reset), .lnk(lnk), .lim_clr(1'b0), .busy());
    nds_dev u_nds_dev2 (.clk_sys(clk_sys), .reset(reset), .lnk(lnk2), .lim_clr(lim_clr2), .busy(busy2));
    nds_host u_nds_host (.clk_sys(clk_sys), .reset(reset), .lnk(lnk), .start(start),
        .dividend(dividend), .divisor(divisor), .nbits(nbits), .src_sel(src_sel),
        .dst_sel(dst_sel), .quotient(quotient), .remainder(remainder), .done(done),
        .busy(), .invalid(invalid));
    nds_asserts u_nds_asserts (.clk_sys(clk_sys), .reset(reset), .step_valid(lnk.step_valid),
        .step_ready(lnk.step_ready), .step_done(lnk.step_done), .step_src_sel(lnk.step_src_sel),
        .step_dst_sel(lnk.step_dst_sel), .acc_wr_en(lnk.acc_wr_en), .acc_wr_sel(lnk.acc_wr_sel),
        .acc_wr_data(lnk.acc_wr_data), .reg_wr_en(lnk.reg_wr_en), .reg_wr_sel(lnk.reg_wr_sel),
        .reg_wr_data(lnk.reg_wr_data), .acc_a(lnk.acc_a), .acc_b(lnk.acc_b),
        .flag_c(lnk.flag_c), .flag_v(lnk.flag_v), .flag_l(lnk.flag_l));

    // ********************************************************
    // compare and closing report
    // ********************************************************
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d bad=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one full signed divide through the issuer
    task automatic run_div(input logic [31:0] dd, input logic [15:0] dv, input logic [4:0] nb,
                           input logic [1:0] ss, input logic ds);
        logic [31:0] md;
        logic [31:0] mv;
        logic [31:0] q;
        logic [19:0] r;
        logic        bad;
        int          n;
        int          k;
        md = dd[31] ? 32'h0 - dd : dd;
        mv = {16'h0, (dv[15] ? 16'h0 - dv : dv)};
        n = (nb == 5'h0 || nb > 5'h10) ? 16 : int'(nb);
        bad = (mv == 32'h0) || (md >= (mv << 16));
        q = bad ? 32'h0 : md / (mv << (16 - n));
        r = bad ? 20'h0 : 20'(md % mv);
        if (dd[31] ^ dv[15]) q = 32'h0 - q;
        if (dd[31]) r = 20'h0 - r;
        @(posedge clk_sys);
        {start, dividend, divisor, nbits, src_sel, dst_sel} <= {1'b1, dd, dv, nb, ss, ds};
        @(posedge clk_sys);
        start <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 200) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k >= 200) begin
            bad_count++;
            report_and_stop();
        end
        chk(36'(invalid), 36'(bad));
        if (!bad) chk(36'(quotient), 36'(q[15:0]));
        if (!bad && n == 16) chk(36'(remainder), 36'(r));
    endtask

    // bare unit: overflow step, refused load, limit clear
    task automatic dev_direct;
        @(posedge clk_sys);
        {lnk2.reg_wr_en, lnk2.reg_wr_sel, lnk2.reg_wr_data} <= {1'b1, 2'h2, 16'h3};
        {lnk2.acc_wr_en, lnk2.acc_wr_sel, lnk2.acc_wr_data} <= {1'b1, 1'b1, 36'h400000005};
        {lnk2.c_wr_en, lnk2.c_wr_val} <= 2'h3;
        @(posedge clk_sys);
        {lnk2.reg_wr_en, lnk2.c_wr_en, lnk2.acc_wr_en} <= 3'h0;
        {lnk2.step_valid, lnk2.step_src_sel, lnk2.step_dst_sel} <= 4'hd;
        @(posedge clk_sys);
        lnk2.acc_wr_en <= 1'b1;
        lnk2.acc_wr_data <= 36'h123456789;
        #1;
        chk(36'({busy2, lnk2.step_ready}), 36'h2);
        @(posedge clk_sys);
        lnk2.step_valid <= 1'b0;
        lnk2.acc_wr_en <= 1'b0;
        #1;
        chk(36'(lnk2.step_done), 36'h1);
        chk(lnk2.acc_b, 36'h7fffd000b);
        chk(36'({lnk2.flag_c, lnk2.flag_v, lnk2.flag_l}), 36'h7);
        @(posedge clk_sys);
        #1;
        chk(36'(lnk2.step_done), 36'h0);
        chk(lnk2.acc_b, 36'h7fffd000b);
        lim_clr2 <= 1'b1;
        @(posedge clk_sys);
        lim_clr2 <= 1'b0;
        #1;
        chk(36'(lnk2.flag_l), 36'h0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        reset = 1'b1;
        start = 1'b0;
        dividend = 32'h0;
        divisor = 16'h0;
        nbits = 5'h0;
        src_sel = 2'h0;
        dst_sel = 1'b0;
        lim_clr2 = 1'b0;
        {lnk2.step_valid, lnk2.step_src_sel, lnk2.step_dst_sel} = 4'h0;
        {lnk2.acc_wr_en, lnk2.acc_wr_sel, lnk2.acc_wr_data} = 38'h0;
        {lnk2.reg_wr_en, lnk2.reg_wr_sel, lnk2.reg_wr_data} = 19'h0;
        {lnk2.c_wr_en, lnk2.c_wr_val} = 2'h0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        dev_direct();
        run_div(32'h00123456, 16'h0100, 5'h10, 2'h0, 1'b0);
        run_div(32'hfffffc18, 16'h0007, 5'h10, 2'h1, 1'b1);
        run_div(32'h000003e8, 16'hfff9, 5'h10, 2'h2, 1'b0);
        run_div(32'hfffffc18, 16'hfff9, 5'h00, 2'h3, 1'b1);
        run_div(32'h000186a0, 16'h0003, 5'h04, 2'h0, 1'b1);
        run_div(32'h00008000, 16'h0001, 5'h01, 2'h1, 1'b0);
        run_div(32'h00000064, 16'h0003, 5'h11, 2'h2, 1'b1);
        run_div(32'h0000fffe, 16'h0002, 5'h10, 2'h3, 1'b0);
        run_div(32'h00000005, 16'h0000, 5'h10, 2'h0, 1'b0);
        run_div(32'h00011170, 16'h0001, 5'h10, 2'h1, 1'b1);
        report_and_stop();
    end
endmodule
